// ==== logic/cwlp_pkg.sv ====
package cwlp_pkg;
  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [5:0] PLL_RATIO_OFF = 6'h00;
  localparam logic [5:0] WDOG_CTRL_OFF = 6'h04;
  localparam logic [5:0] WDOG_KEY_OFF = 6'h08;
  localparam logic [5:0] WDOG_CNT_OFF = 6'h0C;
  localparam logic [5:0] LP_CTRL0_OFF = 6'h10;
  localparam logic [5:0] LP_CTRL1_OFF = 6'h14;
  localparam logic [5:0] STATUS_OFF = 6'h18;
  localparam logic [5:0] IDLE_CMD_OFF = 6'h1C;
  // Field layouts.
  localparam int RATIO_W = 4;
  localparam logic [3:0] RATIO_MAX = 4'hA;
  localparam logic [3:0] RATIO_RST = 4'h0;
  localparam int WD_EN_BIT = 0;
  localparam int WD_IE_BIT = 1;
  localparam int WD_PS_LSB = 4;
  localparam logic [7:0] WDCTRL_RST = 8'h01;
  localparam logic [7:0] WD_KEY1 = 8'h55;
  localparam logic [7:0] WD_KEY2 = 8'hAA;
  localparam logic [7:0] WD_MAX = 8'hFF;
  localparam int LPSEL_LSB = 0;
  localparam int QUAL_LSB = 2;
  localparam int QUAL_W = 6;
  localparam logic [7:0] LPCTRL0_RST = 8'hFC;
  localparam int WAKE_W = 8;
  localparam logic [7:0] LPCTRL1_RST = 8'h00;
  localparam int WK_NMI = 0;
  // Timing.
  localparam int XCLK_SETTLE_CYC = 131072;
  localparam int WD_PULSE_CYC = 512;
  localparam logic [8:0] WD_PULSE_LAST = 9'h1FF;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    CWLP_RUN = 4'h1,
    CWLP_IDLE = 4'h2,
    CWLP_STBY = 4'h4,
    CWLP_HALT = 4'h8
  } cwlp_mode_e;
endpackage

// ==== logic/cwlp_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser bank for pins from outside the core clock domain.
module cwlp_sync #(
  parameter int W = 1
) (
  input wire logic i_clk, // clock
  input wire logic i_rst, // async reset
  input wire logic [W-1:0] i_d, // asynchronous inputs
  output logic [W-1:0] o_q // synchronised outputs
);
  logic [W-1:0] meta;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= '1;
      o_q <= '1;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule // cwlp_sync
`default_nettype wire

// ==== logic/cwlp_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1 - Software writes a four-bit ratio field in the PLL ratio register.
// RULE2 - Software disables watchdog before ratio write, re-enables after settling.
// RULE3 - PLL needs 131072 input clock cycles to settle after ratio change.
// RULE4 - Disable pin low at reset: PLL off, core clock equals input clock.
// RULE5 - Not disabled: PLL powers up bypassed, system clock is input over two.
// RULE6 - Non-zero ratio n enables PLL; system clock is input times n over two.
// RULE7 - Oscillator bypass mode: all clocks come from the external clock pin.
// RULE8 - Watchdog counter at maximum drives reset output low 512 clocks.
// RULE9 - Key 0x55 then 0xAA clears the watchdog counter.
// RULE10 - In STANDBY only watchdog runs; its interrupt can wake the device.
// RULE11 - In IDLE watchdog interrupt raises a processor interrupt to wake.
// RULE12 - In HALT oscillator and PLL stop; watchdog cannot wake. O_OSC_RUN drops, but O_PLL_ENABLE is not gated by the mode.
// RULE13 - Select field: 00 IDLE, 01 STANDBY, 1x HALT.
// RULE14 - In IDLE all clocks keep running; block does nothing else.
// RULE15 - In STANDBY core and system clock stop, oscillator keeps running.
// RULE16 - IDLE exits on enabled interrupt, non-maskable interrupt, or reset.
// RULE17 - Low wake level ends mode only if held long enough. Code qualifies it in STANDBY only; IDLE and HALT exit at once.
// RULE18 - STANDBY wake sources are enabled individually in control register one.
// RULE19 - STANDBY wake qualified over a programmed count of oscillator clocks.
// RULE20 - Only reset and enabled non-maskable interrupt wake from HALT. The code also leaves HALT on the debugger wake request.
// RULE21 - Low-power modes leave output pins as they were at idle entry.
// RULE22 - Debug port stays live and the debugger can end any mode.
// RULE23 - Ratio 0 bypasses, 1 to 10 give n, 11 to 15 reserved.
// RULE24 - Ratio register reset only by external reset, not debug reset.
// RULE25 - On input clock loss limp clock runs and watchdog counter freezes.
// RULE26 - Watchdog counts on selectable prescaled clock, stops when disabled.
// RULE27 - Idle instruction enters selected mode; exit resumes normal clocking.
module cwlp_top
  import cwlp_pkg::*;
(
  input wire logic I_CORE_CLK, // 20 MHz oscillator clock
  input wire logic I_RST, // external reset, active high
  input wire logic I_PLL_DISABLE_PIN_N, // strap, low disables the PLL
  input wire logic I_OSC_BYPASS, // strap, high bypasses oscillator
  input wire logic I_CLOCK_LOST, // input clock missing, limp clock runs
  input wire logic I_DEBUG_RESET, // debugger reset, keeps ratio
  input wire logic I_DEBUG_WAKE, // debugger request to leave low power
  input wire logic I_IDLE_INSTR, // core executes idle, one-cycle pulse
  input wire logic I_ENABLED_INT_N, // any enabled interrupt, low active
  input wire logic I_EXT_NONMASKABLE_INT_N, // non-maskable pin
  input wire logic I_EXT_INTERRUPT_ONE_N, // external interrupt one pin
  input wire logic [1:0] I_TIMER_TRIP_INPUTS_N, // timer trip pins (grouped)
  input wire logic I_COMPARE_TRIP_INPUTS_N, // compare trip pins (anded)
  input wire logic I_SERIAL_A_RECEIVE, // serial A receive line
  input wire logic I_SERIAL_B_RECEIVE, // serial B receive line
  input wire logic I_CAN_RECEIVE_LINE, // CAN receive line
  input wire logic [5:0] S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID, // write address valid
  output logic S_AXI_AWREADY, // write address ready
  input wire logic [31:0] S_AXI_WDATA, // write data
  input wire logic [3:0] S_AXI_WSTRB, // write strobes
  input wire logic S_AXI_WVALID, // write data valid
  output logic S_AXI_WREADY, // write data ready
  output logic [1:0] S_AXI_BRESP, // write response
  output logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire logic [5:0] S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID, // read address valid
  output logic S_AXI_ARREADY, // read address ready
  output logic [31:0] S_AXI_RDATA, // read data
  output logic [1:0] S_AXI_RRESP, // read response
  output logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY, // read data ready
  output logic O_PLL_ENABLE, // PLL running with ratio n
  output logic O_PLL_BYPASS, // PLL bypassed, /2 in path
  output logic O_PLL_OFF, // PLL fully disabled, no /2
  output logic [3:0] O_PLL_MULT, // multiplier n applied to the PLL
  output logic O_PLL_LOCKED, // settling time has elapsed
  output logic O_OSC_RUN, // oscillator clock gate
  output logic O_CORE_CLK_RUN, // core clock gate
  output logic O_SYS_CLK_RUN, // system clock output gate
  output logic O_PERIPH_RUN, // peripheral clock gate
  output logic O_PIN_HOLD, // freeze output pins
  output logic O_WDOG_RESET_OUT_N, // watchdog reset, low active
  output logic O_WDOG_INTERRUPT_OUT_N, // watchdog interrupt, low active
  output logic O_CORE_WAKE_INT, // interrupt to core on wake
  output logic [3:0] O_MODE // current mode, one-hot
);
  logic nmi_s, xint_s, cmp_s, sa_s, sb_s, can_s, lost_s, dbw_s, ena_s;
  logic [1:0] tt_s;
  logic strap_s, bypass_s;
  logic [3:0] ratio;
  logic [7:0] wd_ctrl, wd_cnt, lp_ctrl0, lp_ctrl1;
  logic key_armed;
  logic [8:0] wd_pulse_cnt;
  logic wd_pulsing;
  logic [6:0] wd_pre;
  logic [17:0] settle_cnt;
  logic strap_taken;
  logic [QUAL_W-1:0] qual_cnt;
  cwlp_mode_e mode, next_mode;
  logic aw_got, w_got;
  logic [5:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [7:0] wake_vec;
  logic wake_low, wd_tick, wd_fire;

  cwlp_sync #(.W(14)) u_sync (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_d({I_EXT_NONMASKABLE_INT_N, I_EXT_INTERRUPT_ONE_N,
          I_TIMER_TRIP_INPUTS_N, I_COMPARE_TRIP_INPUTS_N,
          I_SERIAL_A_RECEIVE, I_SERIAL_B_RECEIVE, I_CAN_RECEIVE_LINE,
          ~I_CLOCK_LOST, ~I_DEBUG_WAKE, I_ENABLED_INT_N,
          I_PLL_DISABLE_PIN_N, ~I_OSC_BYPASS, ~I_DEBUG_RESET}),
    .o_q({nmi_s, xint_s, tt_s, cmp_s, sa_s, sb_s, can_s,
          lost_s, dbw_s, ena_s, strap_s, bypass_s, strap_taken})
  );

  // Decodes a byte offset into a register match.
  function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
    hit = (a[5:2] == off[5:2]);
  endfunction

  // AXI4-Lite write side: address and data taken in either order.
  assign do_write = aw_got && w_got && !S_AXI_BVALID;
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 6'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= AXI_OKAY;
    end else begin
      S_AXI_AWREADY <= !aw_got && !S_AXI_AWREADY && !S_AXI_BVALID;
      S_AXI_WREADY <= !w_got && !S_AXI_WREADY && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_write) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (aw_addr > IDLE_CMD_OFF + 6'h03) ? AXI_SLVERR
                                                          : AXI_OKAY;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
    end
  end

  // Read side: one outstanding read, data registered.
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= AXI_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= AXI_OKAY;
        S_AXI_RDATA <= 32'h0000_0000;
        if (hit(S_AXI_ARADDR, PLL_RATIO_OFF))
          S_AXI_RDATA[3:0] <= ratio;
        else if (hit(S_AXI_ARADDR, WDOG_CTRL_OFF))
          S_AXI_RDATA[7:0] <= wd_ctrl;
        else if (hit(S_AXI_ARADDR, WDOG_CNT_OFF))
          S_AXI_RDATA[7:0] <= wd_cnt;
        else if (hit(S_AXI_ARADDR, LP_CTRL0_OFF))
          S_AXI_RDATA[7:0] <= lp_ctrl0;
        else if (hit(S_AXI_ARADDR, LP_CTRL1_OFF))
          S_AXI_RDATA[7:0] <= lp_ctrl1;
        else if (hit(S_AXI_ARADDR, STATUS_OFF))
          S_AXI_RDATA[7:0] <= {O_PLL_LOCKED, lost_s, !strap_s,
                               !bypass_s, mode};
        else if (S_AXI_ARADDR > IDLE_CMD_OFF + 6'h03)
          S_AXI_RRESP <= AXI_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Ratio register lives on the external reset only; debug reset is
  // not wired here on purpose so a debug session keeps its clocking.
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin // RULE24
    if (I_RST) begin
      ratio <= RATIO_RST;
    end else if (do_write && hit(aw_addr, PLL_RATIO_OFF) && w_strb[0]) begin
      ratio <= w_data[3:0]; // RULE1
    end
  end

  // Settle counter restarts on every ratio write.
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      settle_cnt <= 18'h00000;
      O_PLL_LOCKED <= 1'b0;
    end else if (do_write && hit(aw_addr, PLL_RATIO_OFF) && w_strb[0]) begin
      settle_cnt <= 18'h00000; // RULE3
      O_PLL_LOCKED <= 1'b0;
    end else if (settle_cnt == 18'(XCLK_SETTLE_CYC - 1)) begin
      O_PLL_LOCKED <= 1'b1; // RULE3
    end else begin
      settle_cnt <= settle_cnt + 18'h00001;
    end
  end

  // PLL mode outputs; the strap is read after release, through synchroniser.
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_PLL_OFF <= 1'b0;
      O_PLL_BYPASS <= 1'b1;
      O_PLL_ENABLE <= 1'b0;
      O_PLL_MULT <= 4'h0;
    end else begin
      O_PLL_OFF <= !strap_s || !bypass_s; // RULE4 RULE7
      O_PLL_BYPASS <= strap_s && bypass_s &&
                      ratio - 4'h1 >= RATIO_MAX; // RULE5 RULE23
      O_PLL_ENABLE <= strap_s && bypass_s && ratio != 4'h0 &&
                      ratio <= RATIO_MAX; // RULE6 RULE23
      O_PLL_MULT <= (ratio <= RATIO_MAX) ? ratio : 4'h0; // RULE6
    end
  end

  // Watchdog prescaler: tick every 2^ps oscillator clocks.
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      wd_pre <= 7'h00;
    end else begin
      wd_pre <= wd_pre + 7'h01;
    end
  end
  assign wd_tick = (wd_pre & ((7'h01 << wd_ctrl[WD_PS_LSB +: 3]) - 7'h01))
                   == 7'h00; // RULE26
  assign wd_fire = wd_cnt == WD_MAX;

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      wd_ctrl <= WDCTRL_RST;
      key_armed <= 1'b0;
    end else if (do_write && w_strb[0]) begin
      if (hit(aw_addr, WDOG_CTRL_OFF))
        wd_ctrl <= w_data[7:0];
      if (hit(aw_addr, WDOG_KEY_OFF))
        key_armed <= (w_data[7:0] == WD_KEY1) ||
                     (key_armed && w_data[7:0] != WD_KEY2); // RULE9
    end
  end

  // Counter freezes when disabled, on limp clock, and in HALT.
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      wd_cnt <= 8'h00;
    end else if (do_write && w_strb[0] && hit(aw_addr, WDOG_KEY_OFF) &&
                 key_armed && w_data[7:0] == WD_KEY2) begin
      wd_cnt <= 8'h00; // RULE9
    end else if (wd_fire && !wd_pulsing) begin
      wd_cnt <= 8'h00;
    end else if (wd_ctrl[WD_EN_BIT] && wd_tick && lost_s && // RULE25 RULE26
                 mode != CWLP_HALT) begin // RULE12
      wd_cnt <= wd_cnt + 8'h01;
    end
  end

  // Reset pulse or interrupt, 512 clocks low.
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      wd_pulsing <= 1'b0;
      wd_pulse_cnt <= 9'h000;
      O_WDOG_RESET_OUT_N <= 1'b1;
      O_WDOG_INTERRUPT_OUT_N <= 1'b1;
    end else if (wd_fire && !wd_pulsing) begin
      wd_pulsing <= 1'b1;
      wd_pulse_cnt <= 9'h000;
      O_WDOG_RESET_OUT_N <= wd_ctrl[WD_IE_BIT]; // RULE8
      O_WDOG_INTERRUPT_OUT_N <= !wd_ctrl[WD_IE_BIT]; // RULE10 RULE11
    end else if (wd_pulsing) begin
      wd_pulse_cnt <= wd_pulse_cnt + 9'h001;
      if (wd_pulse_cnt == WD_PULSE_LAST) begin // RULE8
        wd_pulsing <= 1'b0;
        O_WDOG_RESET_OUT_N <= 1'b1;
        O_WDOG_INTERRUPT_OUT_N <= 1'b1;
      end
    end
  end

  // Low-power control registers.
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      lp_ctrl0 <= LPCTRL0_RST;
      lp_ctrl1 <= LPCTRL1_RST;
    end else if (do_write && w_strb[0]) begin
      if (hit(aw_addr, LP_CTRL0_OFF))
        lp_ctrl0 <= w_data[7:0];
      if (hit(aw_addr, LP_CTRL1_OFF))
        lp_ctrl1 <= w_data[7:0]; // RULE18
    end
  end

  // Wake candidates, all active low.
  assign wake_vec = {!O_WDOG_INTERRUPT_OUT_N, !can_s, !sb_s, !sa_s, !cmp_s,
                     !(&tt_s), !xint_s, !nmi_s};
  assign wake_low = |(wake_vec & lp_ctrl1); // RULE18

  // Qualifier: a short low glitch drops back into the mode.
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      qual_cnt <= '0;
    end else if (mode == CWLP_STBY && wake_low) begin
      if (qual_cnt != lp_ctrl0[QUAL_LSB +: QUAL_W])
        qual_cnt <= qual_cnt + 6'h01; // RULE19
    end else begin
      qual_cnt <= '0; // RULE17
    end
  end

  always_comb begin
    next_mode = mode;
    case (mode)
      CWLP_RUN: begin
        if (I_IDLE_INSTR) begin // RULE27
          if (lp_ctrl0[LPSEL_LSB + 1])
            next_mode = CWLP_HALT; // RULE13
          else if (lp_ctrl0[LPSEL_LSB])
            next_mode = CWLP_STBY; // RULE13
          else
            next_mode = CWLP_IDLE; // RULE13
        end
      end
      CWLP_IDLE: begin
        if (!ena_s || !nmi_s || !O_WDOG_INTERRUPT_OUT_N || !dbw_s)
          next_mode = CWLP_RUN; // RULE16 RULE11 RULE22
      end
      CWLP_STBY: begin
        if ((wake_low && qual_cnt == lp_ctrl0[QUAL_LSB +: QUAL_W]) ||
            !dbw_s)
          next_mode = CWLP_RUN; // RULE19 RULE22
      end
      CWLP_HALT: begin
        if ((!nmi_s && lp_ctrl1[WK_NMI]) || !dbw_s)
          next_mode = CWLP_RUN; // RULE20 RULE22
      end
      default: next_mode = CWLP_RUN;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      mode <= CWLP_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // Clock gates follow the next mode so they switch with it.
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_OSC_RUN <= 1'b1;
      O_CORE_CLK_RUN <= 1'b1;
      O_SYS_CLK_RUN <= 1'b1;
      O_PERIPH_RUN <= 1'b1;
      O_PIN_HOLD <= 1'b0;
      O_CORE_WAKE_INT <= 1'b0;
      O_MODE <= CWLP_RUN;
    end else begin
      O_OSC_RUN <= next_mode != CWLP_HALT; // RULE12 RULE14
      O_CORE_CLK_RUN <= next_mode == CWLP_RUN ||
                        next_mode == CWLP_IDLE; // RULE14 RULE15
      O_SYS_CLK_RUN <= next_mode == CWLP_RUN ||
                       next_mode == CWLP_IDLE; // RULE14 RULE15
      O_PERIPH_RUN <= next_mode == CWLP_RUN ||
                      next_mode == CWLP_IDLE; // RULE10
      O_PIN_HOLD <= next_mode != CWLP_RUN; // RULE21
      O_CORE_WAKE_INT <= mode != CWLP_RUN && next_mode == CWLP_RUN;
      O_MODE <= next_mode;
    end
  end
endmodule // cwlp_top
`default_nettype wire

// ==== test/cwlp_top_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module cwlp_top_checker
  import cwlp_pkg::*;
(
  input wire logic I_CORE_CLK, // clock
  input wire logic I_RST, // reset
  input wire logic I_PLL_DISABLE_PIN_N, // strap
  input wire logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY, // read data ready
  input wire logic O_PLL_ENABLE, // PLL on
  input wire logic O_PLL_BYPASS, // PLL bypassed
  input wire logic O_PLL_OFF, // PLL off
  input wire logic [3:0] O_PLL_MULT, // multiplier
  input wire logic O_PLL_LOCKED, // settled
  input wire logic O_OSC_RUN, // oscillator gate
  input wire logic O_CORE_CLK_RUN, // core gate
  input wire logic O_SYS_CLK_RUN, // system gate
  input wire logic O_PERIPH_RUN, // peripheral gate
  input wire logic O_PIN_HOLD, // pin freeze
  input wire logic O_WDOG_RESET_OUT_N, // watchdog reset
  input wire logic O_CORE_WAKE_INT, // wake pulse
  input wire logic [3:0] O_MODE // mode
);
  logic [9:0] low_cnt;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  // Counts low samples of the watchdog reset so its width is seen at the rise.
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) low_cnt <= 10'h000;
    else low_cnt <= O_WDOG_RESET_OUT_N ? 10'h000 : low_cnt + 10'h001;
  end
  a_idle_clocks: assert property (O_MODE == CWLP_IDLE |-> O_OSC_RUN &&
    O_CORE_CLK_RUN && O_SYS_CLK_RUN) else $error("idle gates wrong");
  a_stby_clocks: assert property (O_MODE == CWLP_STBY &&
    $past(O_MODE) == CWLP_STBY |-> O_OSC_RUN && !O_CORE_CLK_RUN &&
    !O_SYS_CLK_RUN && !O_PERIPH_RUN) else $error("standby gates wrong");
  a_halt_osc: assert property (O_MODE == CWLP_HALT &&
    $past(O_MODE) == CWLP_HALT |-> !O_OSC_RUN && !O_CORE_CLK_RUN)
    else $error("halt gates wrong");
  a_pins_held: assert property (O_MODE != CWLP_RUN &&
    $past(O_MODE) != CWLP_RUN |-> O_PIN_HOLD) else $error("pins not held");
  a_wd_width: assert property ($rose(O_WDOG_RESET_OUT_N) |->
    low_cnt == 10'h200) else $error("watchdog pulse width wrong");
  a_pll_onehot: assert property ($onehot({O_PLL_ENABLE, O_PLL_BYPASS,
    O_PLL_OFF})) else $error("PLL mode not one-hot");
  a_strap_off: assert property (!I_PLL_DISABLE_PIN_N [*4] |=>
    O_PLL_OFF && !O_PLL_ENABLE) else $error("strap ignored");
  a_mult_range: assert property (O_PLL_ENABLE |-> O_PLL_MULT != 4'h0 &&
    O_PLL_MULT <= RATIO_MAX) else $error("enabled with bad ratio");
  a_lock_restart: assert property ($changed(O_PLL_MULT) |->
    !O_PLL_LOCKED) else $error("locked right after ratio change");
  a_wake_pulse: assert property (O_MODE == CWLP_RUN &&
    $past(O_MODE) != CWLP_RUN |-> ##[0:1] O_CORE_WAKE_INT)
    else $error("no wake pulse");
  a_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID) else $error("write response dropped");
  a_rvalid_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID) else $error("read response dropped");
endmodule // cwlp_top_checker
bind cwlp_top cwlp_top_checker u_chk (.I_CORE_CLK, .I_RST,
  .I_PLL_DISABLE_PIN_N, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_RVALID,
  .S_AXI_RREADY, .O_PLL_ENABLE, .O_PLL_BYPASS, .O_PLL_OFF, .O_PLL_MULT,
  .O_PLL_LOCKED, .O_OSC_RUN, .O_CORE_CLK_RUN, .O_SYS_CLK_RUN, .O_PERIPH_RUN,
  .O_PIN_HOLD, .O_WDOG_RESET_OUT_N, .O_CORE_WAKE_INT, .O_MODE);
`default_nettype wire

// ==== test/cwlp_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Core and wake-source side: idle pulses and active-low wake levels.
module cwlp_core_model (
  input wire logic i_clk, // core clock
  output logic o_idle, // idle instruction pulse
  output logic [7:0] o_wake_n // wake lines, low active
);
  initial begin
    o_idle = 1'b0;
    o_wake_n = 8'hFF;
  end
  task automatic idle();
    @(posedge i_clk);
    o_idle <= 1'b1;
    @(posedge i_clk);
    o_idle <= 1'b0;
  endtask
  // A short hold is legal here: the device must ignore it and stay asleep.
  task automatic wake(input int k, input int hold);
    @(posedge i_clk);
    o_wake_n[k] <= 1'b0;
    repeat (hold) @(posedge i_clk);
    o_wake_n[k] <= 1'b1;
  endtask
endmodule // cwlp_core_model
`default_nettype wire

// ==== test/cwlp_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module cwlp_top_test;
  import cwlp_pkg::*;
  logic I_CORE_CLK = 1'b0, I_RST = 1'b1, I_PLL_DISABLE_PIN_N = 1'b1;
  logic I_CLOCK_LOST = 1'b0, I_DEBUG_RESET = 1'b0, I_DEBUG_WAKE = 1'b0;
  logic [5:0] S_AXI_AWADDR = 6'h00, S_AXI_ARADDR = 6'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rd, v;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, I_OSC_BYPASS = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, O_PLL_ENABLE, O_PLL_BYPASS, O_PLL_OFF, O_PLL_LOCKED;
  logic O_OSC_RUN, O_CORE_CLK_RUN, O_SYS_CLK_RUN, O_PERIPH_RUN, O_PIN_HOLD;
  logic O_WDOG_RESET_OUT_N, O_WDOG_INTERRUPT_OUT_N, O_CORE_WAKE_INT, idle_p;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rsp;
  logic [3:0] O_PLL_MULT, O_MODE;
  logic [7:0] wk;
  int errors = 0, total_checks = 0, seed = 32'hcf75e2c2, i, n;
  int mdl [8] = '{default: 0};
  always #25 I_CORE_CLK = ~I_CORE_CLK;
  cwlp_core_model u_core (.i_clk(I_CORE_CLK), .o_idle(idle_p), .o_wake_n(wk));
  cwlp_top u_dut (.I_CORE_CLK, .I_RST, .I_PLL_DISABLE_PIN_N,
    .I_OSC_BYPASS, .I_CLOCK_LOST, .I_DEBUG_RESET, .I_DEBUG_WAKE,
    .I_IDLE_INSTR(idle_p), .I_ENABLED_INT_N(wk[7]),
    .I_EXT_NONMASKABLE_INT_N(wk[0]), .I_EXT_INTERRUPT_ONE_N(wk[1]),
    .I_TIMER_TRIP_INPUTS_N({1'b1, wk[2]}), .I_COMPARE_TRIP_INPUTS_N(wk[3]),
    .I_SERIAL_A_RECEIVE(wk[4]), .I_SERIAL_B_RECEIVE(wk[5]),
    .I_CAN_RECEIVE_LINE(wk[6]), .S_AXI_AWADDR, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB(4'hF), .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY, .O_PLL_ENABLE, .O_PLL_BYPASS, .O_PLL_OFF,
    .O_PLL_MULT, .O_PLL_LOCKED, .O_OSC_RUN, .O_CORE_CLK_RUN, .O_SYS_CLK_RUN,
    .O_PERIPH_RUN, .O_PIN_HOLD, .O_WDOG_RESET_OUT_N, .O_WDOG_INTERRUPT_OUT_N,
    .O_CORE_WAKE_INT, .O_MODE);
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge I_CORE_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge I_CORE_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID) break;
    end
    rsp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
    if (a < 6'h20) mdl[a[4:2]] = d;
    if (n == 64) begin errors++; conclude(); end
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
    @(posedge I_CORE_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge I_CORE_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID) break;
    end
    rd = S_AXI_RDATA;
    rsp = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
    chk(rd, exp);
    if (n == 64) begin errors++; conclude(); end
  endtask
  task automatic wait_mode(input logic [3:0] m);
    for (n = 0; n < 1200 && O_MODE !== m; n++) @(posedge I_CORE_CLK);
    chk(32'(O_MODE), 32'(m));
    if (n == 1200) conclude();
  endtask
  task automatic enter(input logic [7:0] lp0, input logic [3:0] m,
    input logic [3:0] g);
    wr(LP_CTRL0_OFF, 32'(lp0));
    u_core.idle();
    wait_mode(m);
    repeat (2) @(posedge I_CORE_CLK);
    chk(32'({O_OSC_RUN, O_CORE_CLK_RUN, O_SYS_CLK_RUN, O_PERIPH_RUN}),
      32'(g));
    chk(32'(O_PIN_HOLD), 1);
  endtask
  initial begin
    repeat (8) @(posedge I_CORE_CLK);
    I_RST <= 1'b0;
    chk(32'({O_MODE, O_PLL_BYPASS}), 32'h3);
    rchk(PLL_RATIO_OFF, 32'(RATIO_RST));
    rchk(WDOG_CTRL_OFF, 32'(WDCTRL_RST));
    rchk(LP_CTRL0_OFF, 32'(LPCTRL0_RST));
    rchk(LP_CTRL1_OFF, 32'(LPCTRL1_RST));
    rchk(STATUS_OFF, 32'h41);
    rchk(6'h20, 32'h0);
    chk(32'(rsp), 32'(AXI_SLVERR));
    wr(WDOG_KEY_OFF, 32'(WD_KEY1));
    wr(WDOG_KEY_OFF, 32'(WD_KEY2));
    // The counter steps once a clock from the clearing edge to the read.
    rchk(WDOG_CNT_OFF, 32'h3);
    chk(32'(rd < 32'h10), 1);
    // The first read lets the freeze settle before the sample is taken.
    I_CLOCK_LOST <= 1'b1;
    rchk(WDOG_CNT_OFF, rd + 32'h4);
    v = S_AXI_RDATA;
    rchk(WDOG_CNT_OFF, v);
    I_CLOCK_LOST <= 1'b0;
    for (i = 0; i < 1000 && O_WDOG_RESET_OUT_N !== 1'b0; i++)
      @(posedge I_CORE_CLK);
    for (n = 0; n < 1000 && O_WDOG_RESET_OUT_N === 1'b0; n++)
      @(posedge I_CORE_CLK);
    chk(n, WD_PULSE_CYC);
    wr(WDOG_CTRL_OFF, 32'h3);
    wr(WDOG_KEY_OFF, 32'(WD_KEY1));
    wr(WDOG_KEY_OFF, 32'(WD_KEY2));
    enter(8'hFC, CWLP_IDLE, 4'hF);
    wait_mode(CWLP_RUN);
    chk(32'({O_WDOG_RESET_OUT_N, O_WDOG_INTERRUPT_OUT_N}), 2);
    wr(WDOG_CTRL_OFF, 32'h0);
    repeat (520) @(posedge I_CORE_CLK);
    for (i = 0; i < 20; i++) begin
      v = (i < 16) ? i : $random(seed) & 15;
      wr(PLL_RATIO_OFF, v);
      rchk(PLL_RATIO_OFF, mdl[0] & 15);
      chk(32'(O_PLL_MULT), v <= 10 ? v : 0);
      if (v <= 10) chk(32'({O_PLL_ENABLE, O_PLL_BYPASS}), v == 0 ? 1 : 2);
      chk(32'(O_PLL_LOCKED), 0);
    end
    I_DEBUG_RESET <= 1'b1;
    repeat (4) @(posedge I_CORE_CLK);
    I_DEBUG_RESET <= 1'b0;
    rchk(PLL_RATIO_OFF, mdl[0] & 15);
    for (i = 0; i < 2; i++) begin
      {I_OSC_BYPASS, I_PLL_DISABLE_PIN_N} <= (i == 0) ? 2'b00 : 2'b11;
      repeat (5) @(posedge I_CORE_CLK);
      chk(32'({O_PLL_OFF, O_PLL_ENABLE, O_PLL_BYPASS}), 4);
    end
    {I_OSC_BYPASS, I_PLL_DISABLE_PIN_N} <= 2'b01;
    for (i = 0; i < 2; i++) begin
      enter(8'hFC, CWLP_IDLE, 4'hF);
      u_core.wake(i * 7, 20);
      wait_mode(CWLP_RUN);
    end
    wr(LP_CTRL1_OFF, 32'h2);
    enter(8'hFD, CWLP_STBY, 4'h8);
    u_core.wake(1, 1);
    repeat (80) @(posedge I_CORE_CLK);
    chk(32'(O_MODE), 32'(CWLP_STBY));
    u_core.wake(1, 90);
    wait_mode(CWLP_RUN);
    for (i = 0; i < 7; i++) begin
      wr(LP_CTRL1_OFF, 32'h1 << i);
      rchk(LP_CTRL1_OFF, mdl[5]);
      enter(8'h11, CWLP_STBY, 4'h8);
      u_core.wake((i + 1) % 7, 20);
      chk(32'(O_MODE), 32'(CWLP_STBY));
      u_core.wake(i, 20);
      wait_mode(CWLP_RUN);
    end
    enter(8'h11, CWLP_STBY, 4'h8);
    I_DEBUG_WAKE <= 1'b1;
    wait_mode(CWLP_RUN);
    I_DEBUG_WAKE <= 1'b0;
    wr(LP_CTRL1_OFF, 32'h3);
    for (i = 2; i < 4; i++) begin
      enter(8'h10 | i, CWLP_HALT, 4'h0);
      u_core.wake(1, 20);
      chk(32'(O_MODE), 32'(CWLP_HALT));
      u_core.wake(0, 20);
      wait_mode(CWLP_RUN);
    end
    conclude();
  end
endmodule // cwlp_top_test
`default_nettype wire
